/* File: rtl/ddcdm_top.sv */
// Purpose: Register file and datapath of one down-converter channel plus the
//          output test substitution and phase-offset top byte of its neighbour
// Assumes: All sample, NCO and test-pattern inputs are on clk
// Notes:   Filter cascade is modelled by an integrate-and-dump of equal factor
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps

module ddcdm_top
    import ddcdm_pkg::*;
#(
    parameter int SAMPLE_W = 16
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic [ADDR_W-1:0]            regAddr,
    input  wire logic [REG_W-1:0]             regWrData,
    input  wire logic                         regWr,
    input  wire logic                         regRd,
    output logic [REG_W-1:0]                  regRdData,
    input  wire logic                         sampleValid,
    input  wire logic signed [SAMPLE_W-1:0]   chanA,
    input  wire logic signed [SAMPLE_W-1:0]   chanB,
    input  wire logic signed [SAMPLE_W-1:0]   ncoCos,
    input  wire logic signed [SAMPLE_W-1:0]   ncoSin,
    input  wire logic                         ch2Valid,
    input  wire logic signed [SAMPLE_W-1:0]   ch2I,
    input  wire logic signed [SAMPLE_W-1:0]   ch2Q,
    input  wire logic signed [SAMPLE_W-1:0]   testPatA,
    input  wire logic signed [SAMPLE_W-1:0]   testPatB,
    output logic [REG_W-1:0]                  ch2PhaseOffsetTop,
    output logic                              ch2OutValid,
    output logic signed [SAMPLE_W-1:0]        ch2OutI,
    output logic signed [SAMPLE_W-1:0]        ch2OutQ,
    output logic                              ch3OutValid,
    output logic signed [SAMPLE_W+FACT_W-1:0] ch3OutI,
    output logic signed [SAMPLE_W+FACT_W-1:0] ch3OutQ,
    output logic                              ch3QActive,
    output logic [FACT_W-1:0]                 ch3Factor
);

    localparam int SW = SAMPLE_W;
    localparam int PW = 2 * SW + 1;
    localparam logic signed [SW-1:0] FULL_POS = {1'b0, {(SW-1){1'b1}}};
    localparam logic signed [SW-1:0] FULL_NEG = {1'b1, {(SW-1){1'b0}}};

    if (SAMPLE_W < 8 || SAMPLE_W > 24) begin : g_bad_width
        $error("ddcdm_top: SAMPLE_W must lie between 8 and 24");
    end

    // Register state
    logic [REG_W-1:0] phaseTop_ff;
    logic [REG_W-1:0] testEn_ff;
    logic [REG_W-1:0] ctrl_ff;
    logic [REG_W-1:0] src_ff;
    logic [REG_W-1:0] rdData_ff;
    logic [REG_W-1:0] nxt_rdData;

    // Decoded controls
    logic              complexMix;
    logic              gainTwo;
    ddcdm_if_t         ifMode;
    logic              c2rOn;
    logic [2:0]        decPrim;
    logic [3:0]        decSec;
    logic [FACT_W-1:0] nxt_factor;
    logic [FACT_W-1:0] factor_ff;
    logic              qActive_ff;

    // Mixer pipeline
    logic                 selValid_ff;
    logic signed [SW-1:0] selI_ff;
    logic signed [SW-1:0] selQ_ff;
    logic signed [SW-1:0] loCos_ff;
    logic signed [SW-1:0] loSin_ff;
    logic                 testLevel_ff;
    logic signed [PW-1:0] prodI;
    logic signed [PW-1:0] prodQ;
    logic signed [SW+2:0] scaledI;
    logic signed [SW+2:0] scaledQ;
    logic                 mixValid_ff;
    logic signed [SW-1:0] mixI_ff;
    logic signed [SW-1:0] mixQ_ff;
    logic [1:0]           quarter_ff;

    // Channel-two output stage
    logic                 ch2Valid_ff;
    logic signed [SW-1:0] ch2I_ff;
    logic signed [SW-1:0] ch2Q_ff;

    ddcdm_stream_if #(.SW(SW)) decStrm ();

    function automatic logic signed [SW-1:0] satNarrow(input logic signed [SW+2:0] v);
        logic signed [SW-1:0] r;
        r = v[SW-1:0];
        if (v > $signed({{3{FULL_POS[SW-1]}}, FULL_POS})) begin
            r = FULL_POS;
        end else if (v < $signed({{3{FULL_NEG[SW-1]}}, FULL_NEG})) begin
            r = FULL_NEG;
        end
        return r;
    endfunction

    function automatic logic signed [SW-1:0] negSat(input logic signed [SW-1:0] v);
        return (v == FULL_NEG) ? FULL_POS : -v;
    endfunction

    assign complexMix = ctrl_ff[CTRL_MIX_BIT];
    assign gainTwo    = ctrl_ff[CTRL_GAIN_BIT];
    assign ifMode     = ddcdm_if_t'(ctrl_ff[CTRL_IF_LSB +: 2]);
    assign c2rOn      = ctrl_ff[CTRL_C2R_BIT];
    assign decPrim    = ctrl_ff[CTRL_DEC_LSB +: 3];
    assign decSec     = src_ff[SRC_DEC_LSB +: 4];

    // Register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phaseTop_ff <= RST_PHASE_TOP;
            testEn_ff   <= RST_TEST_EN;
            ctrl_ff     <= RST_CTRL;
            src_ff      <= RST_SRC;
        end else if (regWr) begin
            case (regAddr)
                OFS_PHASE_TOP: phaseTop_ff <= regWrData;
                OFS_TEST_EN:   testEn_ff   <= regWrData & TEST_EN_WR_MASK;
                OFS_CTRL:      ctrl_ff     <= regWrData;
                OFS_SRC:       src_ff      <= regWrData & SRC_WR_MASK;
                default: begin
                end
            endcase
        end
    end

    // Read data stands for exactly the cycle after the read strobe
    always_comb begin
        nxt_rdData = '0;
        if (regRd) begin
            case (regAddr)
                OFS_PHASE_TOP: nxt_rdData = phaseTop_ff;
                OFS_TEST_EN:   nxt_rdData = testEn_ff;
                OFS_CTRL:      nxt_rdData = ctrl_ff;
                OFS_SRC:       nxt_rdData = src_ff;
                default:       nxt_rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_ff <= '0;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    // Halving the complex factor for real output; 011 then gives 1
    always_comb begin
        nxt_factor = ddcdm_factor(decPrim, decSec);
        if (decPrim != DEC_DEFER) begin
            nxt_factor = ddcdm_factor(decPrim, 4'h0);
        end
        if (c2rOn) begin
            nxt_factor = nxt_factor >> 1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            factor_ff  <= RST_FACTOR;
            qActive_ff <= 1'b1;
        end else begin
            factor_ff  <= nxt_factor;
            qActive_ff <= !c2rOn;
        end
    end

    // Stage 1: source select and local oscillator
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            selValid_ff  <= 1'b0;
            selI_ff      <= '0;
            selQ_ff      <= '0;
            loCos_ff     <= '0;
            loSin_ff     <= '0;
            testLevel_ff <= 1'b0;
        end else begin
            selValid_ff <= sampleValid;
            selI_ff     <= src_ff[SRC_ISEL_BIT] ? chanB : chanA;
            // A real mixer has no quadrature input; Q path carries zero
            if (complexMix) begin
                selQ_ff <= src_ff[SRC_QSEL_BIT] ? chanB : chanA;
            end else begin
                selQ_ff <= '0;
            end
            testLevel_ff <= (ifMode == DDCDM_IF_TEST);
            case (ifMode)
                DDCDM_IF_NCO: begin
                    loCos_ff <= ncoCos;
                    loSin_ff <= ncoSin;
                end
                // At fs the oscillator turns once per sample and looks constant
                DDCDM_IF_ZERO, DDCDM_IF_FS: begin
                    loCos_ff <= FULL_POS;
                    loSin_ff <= '0;
                end
                default: begin
                    loCos_ff <= '0;
                    loSin_ff <= '0;
                end
            endcase
        end
    end

    // Multiply by exp(-j w t)
    assign prodI = PW'(selI_ff * loCos_ff) + PW'(selQ_ff * loSin_ff);
    assign prodQ = PW'(selQ_ff * loCos_ff) - PW'(selI_ff * loSin_ff);
    assign scaledI = gainTwo ? (SW + 3)'(prodI >>> (SW - 2))
                             : (SW + 3)'(prodI >>> (SW - 1));
    assign scaledQ = gainTwo ? (SW + 3)'(prodQ >>> (SW - 2))
                             : (SW + 3)'(prodQ >>> (SW - 1));

    // Stage 2: mixer output; test mode feeds full-scale DC on I
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mixValid_ff <= 1'b0;
            mixI_ff     <= '0;
            mixQ_ff     <= '0;
        end else begin
            mixValid_ff <= selValid_ff;
            if (testLevel_ff) begin
                mixI_ff <= FULL_POS;
                mixQ_ff <= '0;
            end else begin
                mixI_ff <= satNarrow(scaledI);
                mixQ_ff <= satNarrow(scaledQ);
            end
        end
    end

    // Stage 3: optional fs/4 rotation to a real stream
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            quarter_ff <= '0;
        end else if (mixValid_ff) begin
            quarter_ff <= quarter_ff + 2'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            decStrm.inValid <= 1'b0;
            decStrm.inI     <= '0;
            decStrm.inQ     <= '0;
        end else begin
            decStrm.inValid <= mixValid_ff;
            if (c2rOn) begin
                case (quarter_ff)
                    2'h0:    decStrm.inI <= mixI_ff;
                    2'h1:    decStrm.inI <= negSat(mixQ_ff);
                    2'h2:    decStrm.inI <= negSat(mixI_ff);
                    default: decStrm.inI <= mixQ_ff;
                endcase
                decStrm.inQ <= '0;
            end else begin
                decStrm.inI <= mixI_ff;
                decStrm.inQ <= mixQ_ff;
            end
        end
    end

    assign decStrm.factor = factor_ff;

    ddcdm_decimator #(
        .SW (SW)
    ) u_decim (
        .clk  (clk),
        .rst  (rst),
        .strm (decStrm)
    );

    // Channel-two test substitution; generator pattern chosen elsewhere
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ch2Valid_ff <= 1'b0;
            ch2I_ff     <= '0;
            ch2Q_ff     <= '0;
        end else begin
            ch2Valid_ff <= ch2Valid;
            ch2I_ff     <= testEn_ff[TEN_I_BIT] ? testPatA : ch2I;
            ch2Q_ff     <= testEn_ff[TEN_Q_BIT] ? testPatB : ch2Q;
        end
    end

    assign regRdData         = rdData_ff;
    assign ch2PhaseOffsetTop = phaseTop_ff;
    assign ch2OutValid       = ch2Valid_ff;
    assign ch2OutI           = ch2I_ff;
    assign ch2OutQ           = ch2Q_ff;
    assign ch3OutValid       = decStrm.outValid;
    assign ch3OutI           = decStrm.outI;
    assign ch3OutQ           = decStrm.outQ;
    assign ch3QActive        = qActive_ff;
    assign ch3Factor         = factor_ff;

endmodule

/* File: pkg/ddcdm_pkg.sv */
// Purpose: Shared constants and helpers for the down-converter control block
// Assumes: Byte-wide registers on a 12-bit register address
// Notes:   Every offset, field position, reset value and count lives here once
package ddcdm_pkg;

    localparam int ADDR_W = 12;
    localparam int REG_W  = 8;
    localparam int FACT_W = 6;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_PHASE_TOP = 12'h362;
    localparam logic [ADDR_W-1:0] OFS_TEST_EN   = 12'h367;
    localparam logic [ADDR_W-1:0] OFS_CTRL      = 12'h370;
    localparam logic [ADDR_W-1:0] OFS_SRC       = 12'h371;

    // Reset values
    localparam logic [REG_W-1:0] RST_PHASE_TOP = 8'h00;
    localparam logic [REG_W-1:0] RST_TEST_EN   = 8'h00;
    localparam logic [REG_W-1:0] RST_CTRL      = 8'h00;
    localparam logic [REG_W-1:0] RST_SRC       = 8'h05;
    localparam logic [FACT_W-1:0] RST_FACTOR   = 6'h02;

    // Writable bits; the rest are reserved and read zero
    localparam logic [REG_W-1:0] TEST_EN_WR_MASK = 8'h05;
    localparam logic [REG_W-1:0] SRC_WR_MASK     = 8'hF5;

    // Field positions
    localparam int TEN_Q_BIT     = 2;
    localparam int TEN_I_BIT     = 0;
    localparam int CTRL_MIX_BIT  = 7;
    localparam int CTRL_GAIN_BIT = 6;
    localparam int CTRL_IF_LSB   = 4;
    localparam int CTRL_C2R_BIT  = 3;
    localparam int CTRL_DEC_LSB  = 0;
    localparam int SRC_DEC_LSB   = 4;
    localparam int SRC_QSEL_BIT  = 2;
    localparam int SRC_ISEL_BIT  = 0;

    localparam logic [2:0] DEC_DEFER = 3'h7;

    typedef enum logic [1:0] {
        DDCDM_IF_NCO,
        DDCDM_IF_ZERO,
        DDCDM_IF_FS,
        DDCDM_IF_TEST
    } ddcdm_if_t;

    // Complex-output decimation factor of the selected filter cascade
    function automatic logic [FACT_W-1:0] ddcdm_factor(input logic [2:0] prim,
                                                       input logic [3:0] sec);
        logic [FACT_W-1:0] f;
        f = 6'h30;
        case (prim)
            3'h0: f = 6'h04;
            3'h1: f = 6'h08;
            3'h2: f = 6'h10;
            3'h3: f = 6'h02;
            3'h4: f = 6'h06;
            3'h5: f = 6'h0C;
            3'h6: f = 6'h18;
            default: begin
                case (sec)
                    4'h0: f = 6'h30;
                    4'h2: f = 6'h0A;
                    4'h3: f = 6'h14;
                    4'h4: f = 6'h28;
                    default: f = 6'h30;
                endcase
            end
        endcase
        return f;
    endfunction

endpackage

/* File: pkg/ddcdm_stream_if.sv */
// Purpose: Carries mixed samples into the decimator and decimated results out
// Assumes: One clock shared by both ends
// Notes:   Accumulated results are wider than the samples by FACT_W bits
`timescale 1ns/100ps
interface ddcdm_stream_if #(
    parameter int SW = 16
);
    import ddcdm_pkg::*;

    logic                       inValid;
    logic signed [SW-1:0]       inI;
    logic signed [SW-1:0]       inQ;
    logic [FACT_W-1:0]          factor;
    logic                       outValid;
    logic signed [SW+FACT_W-1:0] outI;
    logic signed [SW+FACT_W-1:0] outQ;

    modport src (
        output inValid,
        output inI,
        output inQ,
        output factor,
        input  outValid,
        input  outI,
        input  outQ
    );

    modport dec (
        input  inValid,
        input  inI,
        input  inQ,
        input  factor,
        output outValid,
        output outI,
        output outQ
    );

endinterface

/* File: rtl/ddcdm_decimator.sv */
// Purpose: Integrate-and-dump decimator, one result per factor input samples
// Assumes: factor is at least one and changes only between bursts of interest
// Notes:   Results are the raw sum; gain of the cascade equals the factor
`timescale 1ns/100ps
module ddcdm_decimator
    import ddcdm_pkg::*;
#(
    parameter int SW = 16
) (
    input  wire logic   clk,
    input  wire logic   rst,
    ddcdm_stream_if.dec strm
);

    localparam int AW = SW + FACT_W;

    logic [FACT_W-1:0]   cnt_ff;
    logic signed [AW-1:0] accI_ff;
    logic signed [AW-1:0] accQ_ff;
    logic signed [AW-1:0] extI;
    logic signed [AW-1:0] extQ;
    logic                 lastSample;

    assign extI       = {{FACT_W{strm.inI[SW-1]}}, strm.inI};
    assign extQ       = {{FACT_W{strm.inQ[SW-1]}}, strm.inQ};
    // Compare with >= so a factor lowered mid-burst cannot strand the count
    assign lastSample = (cnt_ff >= strm.factor - 6'h01);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff  <= '0;
            accI_ff <= '0;
            accQ_ff <= '0;
        end else if (strm.inValid) begin
            if (lastSample) begin
                cnt_ff  <= '0;
                accI_ff <= '0;
                accQ_ff <= '0;
            end else begin
                cnt_ff  <= cnt_ff + 6'h01;
                accI_ff <= accI_ff + extI;
                accQ_ff <= accQ_ff + extQ;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strm.outValid <= 1'b0;
            strm.outI     <= '0;
            strm.outQ     <= '0;
        end else begin
            strm.outValid <= strm.inValid && lastSample;
            if (strm.inValid && lastSample) begin
                strm.outI <= accI_ff + extI;
                strm.outQ <= accQ_ff + extQ;
            end
        end
    end

endmodule

/* File: sim/ddcdm_adc_model.sv */
// Purpose: Converter channel pair feeding channel three
// Assumes: The bench asks for one burst at a time
// Notes:   Lines toggle between samples so stale data never looks valid
`timescale 1ns/100ps
module ddcdm_adc_model #(
    parameter int SW = 16
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 start,
    input  wire logic [7:0]           count,
    input  wire logic                 slow,
    input  wire logic signed [SW-1:0] valA,
    input  wire logic signed [SW-1:0] valB,
    output logic                      sampleValid,
    output logic signed [SW-1:0]      chanA,
    output logic signed [SW-1:0]      chanB
);
    logic [7:0] left_ff;
    logic       skip_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_ff <= 8'h00;
            skip_ff <= 1'h0;
            sampleValid <= 1'h0;
            chanA <= '0;
            chanB <= '0;
        end else begin
            skip_ff <= slow && !skip_ff;
            sampleValid <= 1'h0;
            chanA <= ~chanA;
            chanB <= ~chanB;
            if (start) begin
                left_ff <= count;
            end else if (left_ff != 8'h00 && !skip_ff) begin
                left_ff <= left_ff - 8'h01;
                sampleValid <= 1'h1;
                chanA <= valA;
                chanB <= valB;
            end
        end
    end
endmodule

/* File: sim/ddcdm_top_monitor.sv */
// Purpose: Port checks of the down-converter control block
// Assumes: Shadow registers decode writes as the block does
// Notes:   Bound into every ddcdm_top
`timescale 1ns/100ps
module ddcdm_top_monitor
    import ddcdm_pkg::*;
#(
    parameter int SAMPLE_W = 16
) (
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic [ADDR_W-1:0]          regAddr,
    input wire logic [REG_W-1:0]           regWrData,
    input wire logic                       regWr,
    input wire logic                       regRd,
    input wire logic [REG_W-1:0]           regRdData,
    input wire logic                       sampleValid,
    input wire logic                       ch2Valid,
    input wire logic signed [SAMPLE_W-1:0] ch2I,
    input wire logic signed [SAMPLE_W-1:0] testPatA,
    input wire logic [REG_W-1:0]           ch2PhaseOffsetTop,
    input wire logic                       ch2OutValid,
    input wire logic signed [SAMPLE_W-1:0] ch2OutI,
    input wire logic                       ch3OutValid,
    input wire logic                       ch3QActive,
    input wire logic [FACT_W-1:0]          ch3Factor
);
    localparam logic [5:0] PF [8] = '{6'h04, 6'h08, 6'h10, 6'h02, 6'h06, 6'h0C, 6'h18, 6'h30};
    localparam logic [5:0] SF [16] = '{2: 6'h0A, 3: 6'h14, 4: 6'h28, default: 6'h30};
    logic [REG_W-1:0]  phase_ff, ten_ff, ctrl_ff, src_ff, expRd;
    logic [FACT_W-1:0] base, expFact;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_ff <= RST_PHASE_TOP;
            ten_ff <= RST_TEST_EN;
            ctrl_ff <= RST_CTRL;
            src_ff <= RST_SRC;
        end else if (regWr) begin
            case (regAddr)
                OFS_PHASE_TOP: phase_ff <= regWrData;
                OFS_TEST_EN:   ten_ff <= regWrData & TEST_EN_WR_MASK;
                OFS_CTRL:      ctrl_ff <= regWrData;
                OFS_SRC:       src_ff <= regWrData & SRC_WR_MASK;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (regAddr)
            OFS_PHASE_TOP: expRd = phase_ff;
            OFS_TEST_EN:   expRd = ten_ff;
            OFS_CTRL:      expRd = ctrl_ff;
            OFS_SRC:       expRd = src_ff;
            default:       expRd = 8'h00;
        endcase
        base = (ctrl_ff[2:0] == DEC_DEFER) ? SF[src_ff[7:4]] : PF[ctrl_ff[2:0]];
        expFact = ctrl_ff[CTRL_C2R_BIT] ? (base >> 1) : base;
    end

    sequence seqPhaseWr;
        regWr && regAddr == OFS_PHASE_TOP;
    endsequence
    // A result needs a sample taken within the last four cycles
    sequence seqInputIdle;
        !sampleValid [*5];
    endsequence
    sequence seqRunning;
        !$past(rst);
    endsequence

    AST_RD_DATA: assert property (regRd |=> regRdData == $past(expRd))
        else $error("read data differs from register contents");
    AST_RD_IDLE: assert property (!regRd |=> regRdData == 8'h00)
        else $error("read data not zero outside a read");
    AST_PHASE_WR: assert property (seqPhaseWr |=> ch2PhaseOffsetTop == $past(regWrData))
        else $error("phase offset top byte not taken from write");
    AST_TEST_I: assert property (ch2Valid |=> ch2OutValid && ch2OutI ==
        ($past(ten_ff[TEN_I_BIT]) ? $past(testPatA) : $past(ch2I)))
        else $error("channel two I output source wrong");
    AST_CH2_VALID: assert property (seqRunning |-> ch2OutValid == $past(ch2Valid))
        else $error("channel two valid not one cycle after input");
    AST_FACTOR: assert property (seqRunning |-> ch3Factor == $past(expFact))
        else $error("decimation factor wrong for selected code");
    AST_QACTIVE: assert property (seqRunning |-> ch3QActive == !$past(ctrl_ff[3]))
        else $error("Q active flag wrong for complex to real");
    AST_IDLE_NO_RESULT: assert property (seqInputIdle |-> !ch3OutValid)
        else $error("decimated result without recent input");
endmodule

bind ddcdm_top ddcdm_top_monitor #(.SAMPLE_W(SAMPLE_W)) i_ddcdm_top_monitor (.*);

/* File: sim/ddcdm_top_tb.sv */
// Purpose: Self-checking bench of the down-converter control block
// Assumes: Converter model sends whole bursts of constant samples
// Notes:   Expected results wait in queues until the outputs show them
`timescale 1ns/100ps
module ddcdm_top_tb;
    import ddcdm_pkg::*;
    localparam int W = 16;
    localparam int OW = W + FACT_W;
    localparam logic [7:0] CT [15] = '{8'h80, 8'hD1, 8'hA2, 8'hC3, 8'h94, 8'hE5, 8'h86, 8'hD7,
                                       8'hA7, 8'hC7, 8'h97, 8'h13, 8'h33, 8'h19, 8'h9E};
    localparam logic [7:0] ST [15] = '{8'h34, 8'h34, 8'h34, 8'h34, 8'h34, 8'h34, 8'h34, 8'h04,
                                       8'h24, 8'h34, 8'h44, 8'h00, 8'h00, 8'h00, 8'h34};
    localparam int         FT [15] = '{4, 8, 16, 2, 6, 12, 24, 48, 10, 20, 40, 2, 2, 4, 12};
    localparam logic [11:0] RA [5] = '{OFS_PHASE_TOP, OFS_TEST_EN, OFS_CTRL, OFS_SRC, 12'h363};
    localparam logic [7:0]  RV [5] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h00};
    localparam logic [7:0]  FV [5] = '{8'hFF, 8'h05, 8'hFF, 8'h45, 8'h00};
    logic                 clk = 1'h0, rst = 1'h1, regWr = 1'h0, regRd = 1'h0, rdLate = 1'h0;
    logic                 ch2Valid = 1'h0, start = 1'h0, slow = 1'h0;
    logic                 sampleValid, ch2OutValid, ch3OutValid, ch3QActive;
    logic [ADDR_W-1:0]    regAddr = '0;
    logic [REG_W-1:0]     regWrData = '0, count = '0, regRdData, ch2PhaseOffsetTop;
    logic signed [W-1:0]  ncoCos = '0, ncoSin = '0, ch2I = '0, ch2Q = '0, valA = '0, valB = '0;
    logic signed [W-1:0]  testPatA = '0, testPatB = '0, chanA, chanB, ch2OutI, ch2OutQ;
    logic signed [OW-1:0] ch3OutI, ch3OutQ;
    logic [FACT_W-1:0]    ch3Factor;
    logic [31:0]          seed = 32'h5D5763BC;
    logic [REG_W-1:0]     rdQ [$];
    logic [2*W-1:0]       c2Q [$];
    logic [2*OW-1:0]      c3Q [$];
    int                   fails = 0, checked = 0;

    ddcdm_top #(.SAMPLE_W(W)) i_ddcdm_top (.*);
    ddcdm_adc_model #(.SW(W)) i_ddcdm_adc_model (.*);

    always #2 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [W-1:0] sat(input longint v);
        return (v > 32767) ? 16'h7FFF : ((v < -32768) ? 16'h8000 : v[15:0]);
    endfunction

    // One mixed sample; oscillator is unity outside variable IF
    function automatic logic [2*W-1:0] mix(input logic [7:0] c, s, input logic signed [W-1:0] a, b);
        logic signed [W-1:0] xi, xq, co, si;
        int                  sh;
        xi = s[SRC_ISEL_BIT] ? b : a;
        xq = !c[CTRL_MIX_BIT] ? '0 : (s[SRC_QSEL_BIT] ? b : a);
        co = (c[5:4] == 2'h0) ? ncoCos : 16'h7FFF;
        si = (c[5:4] == 2'h0) ? ncoSin : 16'h0000;
        sh = c[CTRL_GAIN_BIT] ? 14 : 15;
        if (c[5:4] == 2'h3) return {16'h7FFF, 16'h0000};
        return {sat((longint'(xi) * co + longint'(xq) * si) >>> sh),
                sat((longint'(xq) * co - longint'(xi) * si) >>> sh)};
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        fails += rdQ.size() + c2Q.size() + c3Q.size();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'h1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        regRd <= 1'h1;
        regAddr <= a;
        rdQ.push_back(e);
        @(posedge clk);
        regRd <= 1'h0;
    endtask

    // Bursts are whole multiples of the factor so the count always ends at zero
    task automatic burst(input logic [7:0] c, s, input int f, input logic sl);
        logic [31:0]         r;
        logic signed [W-1:0] ra, rb;
        logic [2*W-1:0]      m;
        logic [2*OW-1:0]     e;
        r = rnd();
        ra = {{4{r[11]}}, r[11:0]};
        rb = {{4{r[27]}}, r[27:16]};
        wr(OFS_CTRL, c);
        wr(OFS_SRC, s);
        repeat (3) @(posedge clk);
        chk(ch3Factor, f);
        chk(ch3QActive, !c[CTRL_C2R_BIT]);
        m = mix(c, s, ra, rb);
        e = c[CTRL_C2R_BIT] ? '0 : {OW'(longint'($signed(m[2*W-1:W])) * f),
                                    OW'(longint'($signed(m[W-1:0])) * f)};
        c3Q.push_back(e);
        c3Q.push_back(e);
        @(posedge clk);
        start <= 1'h1;
        count <= 8'(2 * f);
        slow <= sl;
        valA <= ra;
        valB <= rb;
        @(posedge clk);
        start <= 1'h0;
        for (int k = 0; k < 400 && c3Q.size() != 0; k++) @(posedge clk);
        repeat (6) @(posedge clk);
    endtask

    always @(negedge clk) begin
        if (!rst) begin
            if (rdLate) chk(regRdData, rdQ.pop_front());
            rdLate = regRd;
            if (ch2OutValid) chk({ch2OutI, ch2OutQ}, c2Q.pop_front());
            if (ch3OutValid) chk({ch3OutI, ch3OutQ}, c3Q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out;
    end

    initial begin
        logic [31:0] r, r2;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        for (int i = 0; i < 5; i++) rd(RA[i], RV[i]);
        for (int i = 0; i < 5; i++) wr(RA[i], (i == 3) ? 8'h4F : 8'hFF);
        for (int i = 0; i < 5; i++) rd(RA[i], FV[i]);
        r = rnd();
        wr(OFS_PHASE_TOP, r[7:0]);
        rd(OFS_PHASE_TOP, r[7:0]);
        chk(ch2PhaseOffsetTop, r[7:0]);
        for (int t = 0; t < 4; t++) begin
            wr(OFS_TEST_EN, {5'h00, t[1], 1'h0, t[0]});
            repeat (8) begin
                @(posedge clk);
                r = rnd();
                r2 = rnd();
                ch2Valid <= r2[0];
                ch2I <= r[15:0];
                ch2Q <= r[31:16];
                testPatA <= r2[31:16];
                testPatB <= r2[15:0];
                if (r2[0]) c2Q.push_back({t[0] ? r2[31:16] : r[15:0], t[1] ? r2[15:0] : r[31:16]});
            end
            @(posedge clk);
            ch2Valid <= 1'h0;
        end
        r = rnd();
        ncoCos <= {{2{r[13]}}, r[13:0]};
        ncoSin <= {{2{r[29]}}, r[29:16]};
        for (int i = 0; i < 15; i++) burst(CT[i], ST[i], FT[i], i[0]);
        repeat (10) @(posedge clk);
        close_out;
    end
endmodule
